// ===== rtl/etb_unit.sv
// Trace capture, breakpoint comparators and run control of the emulator
// Behaviour
// - Trace store holds the most recent 1023 machine states.
// - Each sample is 42 channels: 24 processor plus 18 probe.
// - Processor channels: address, data, status, serial in and out.
// - Two breakpoint comparators; either match halts emulation.
// - Two qualifier comparators decide which samples get written.
// - Each comparator has per-channel zero, one or ignore setting.
// - Match when every non-ignored channel equals the current sample.
// - Probe inputs sampled with machine states, stored beside processor channels.
// - Probe channels join comparisons like processor channels.
// - Sync input 0 can enable or disable trace collection.
// - Asserted external sync line 1 breaks emulation.
// - Unit can drive both sync lines from its own events.
// - Trace history stays readable after any halt.
// - Step one instruction or a chosen count, then halt.
// - Once started, run until break match or halt command.
// - Two units start on their own commands only; sync line 1 can stop them in sequence.
// - 32-bit elapsed counter of 2 MHz ticks while running, two halves.
// - Report valid trace frame count from 0 to 1022.
`timescale 1ns/1ps
module etb_unit
   import etb_pkg::*;
(
   input  wire logic                 ref_clk_i,
   input  wire logic                 rstn_i,
   input  wire etb_cpu_t             cpu_i,
   input  wire logic                 state_strobe_i,
   input  wire logic                 instr_done_i,
   input  wire logic [EXT_CH-1:0]    probe_i,
   input  wire logic                 tick_2mhz_i,
   input  wire etb_cmd_t             cmd_i,
   input  wire logic [STEP_W-1:0]    step_count_i,
   input  wire etb_pattern_t         brk_pat0_i,
   input  wire etb_pattern_t         brk_pat1_i,
   input  wire etb_pattern_t         qual_pat0_i,
   input  wire etb_pattern_t         qual_pat1_i,
   input  wire logic                 qual_en_i,
   input  wire etb_sync_cfg_t        sync_cfg_i,
   input  wire logic [1:0]           sync_in_i,
   output logic      [1:0]           sync_out_o,
   output logic      [1:0]           sync_oe_o,
   input  wire logic [PTR_W-1:0]     rd_age_i,
   output logic      [TRACE_CH-1:0]  rd_data_o,
   output logic                      running_o,
   output logic                      halted_o,
   output logic                      break_hit_o,
   output logic      [HALF_W-1:0]    elapsed_count_low_o,
   output logic      [HALF_W-1:0]    elapsed_count_high_o,
   output logic      [PTR_W-1:0]     valid_trace_depth_o
);
   etb_sample_t         smp;
   logic [TRACE_CH-1:0] smp_bits;
   logic [3:0]          hit;
   logic [1:0]          sync_m_ff;
   logic [1:0]          sync_s_ff;
   logic [1:0]          tick_m_ff;
   logic                tick_prev_ff;
   logic                running_ff;
   logic                stepping_ff;
   logic [STEP_W-1:0]   steps_left_ff;
   logic                break_hit_ff;
   logic [TIMER_W-1:0]  timer_ff;
   logic [PTR_W-1:0]    wr_ptr_ff;
   logic [PTR_W-1:0]    valid_ff;
   logic [PTR_W-1:0]    rd_addr;
   logic                ext_gate;
   logic                ext_brk;
   logic                qual_ok;
   logic                brk_now;
   logic                capture;
   logic                step_end;
   logic                tick_rise;
   logic                sync_pulse_ff;

   // Sample word: processor channels high, probe channels low
   assign smp.cpu   = cpu_i;
   assign smp.ext   = probe_i;
   assign smp_bits  = smp;

   // Four comparators; probe bits compare the same way as processor bits
   etb_pattern_t pats [0:3];
   assign pats[0] = brk_pat0_i;
   assign pats[1] = brk_pat1_i;
   assign pats[2] = qual_pat0_i;
   assign pats[3] = qual_pat1_i;
   for (genvar g = 0; g < 4; g++) begin : g_cmp
      // Ignored channels drop out of the compare
      assign hit[g] = ~|(pats[g].care & (pats[g].value ^ smp_bits));
   end

   // Sync inputs come from another aid, so they are synchronised first
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync_m_ff <= 2'h0;
         sync_s_ff <= 2'h0;
         tick_m_ff <= 2'h0;
         tick_prev_ff <= 1'h0;
      end else begin
         sync_m_ff <= sync_in_i;
         sync_s_ff <= sync_m_ff;
         tick_m_ff <= {tick_m_ff[0], tick_2mhz_i};
         tick_prev_ff <= tick_m_ff[1];
      end
   end

   // Line 0 gates the trace, line 1 forces a break; a driven line is not listened to
   assign ext_gate  = ~sync_cfg_i.gate_en | (sync_s_ff[0] & ~sync_oe_o[0]);
   assign ext_brk   = sync_cfg_i.brk_en & sync_s_ff[1] & ~sync_oe_o[1];
   assign qual_ok   = ~qual_en_i | hit[2] | hit[3];
   assign brk_now   = running_ff & state_strobe_i & (hit[0] | hit[1]);
   assign step_end  = running_ff & stepping_ff & instr_done_i & (steps_left_ff <= 16'h0001);
   // Break sample itself is not recorded; writing stops in that very state
   assign capture   = running_ff & state_strobe_i & qual_ok & ext_gate & ~brk_now & ~ext_brk;
   assign tick_rise = tick_m_ff[1] & ~tick_prev_ff;

   // Run control: start on command, stop on break, halt command or step end
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         running_ff <= 1'h0;
         stepping_ff <= 1'h0;
         steps_left_ff <= 16'h0000;
      end else if (running_ff) begin
         if (brk_now || ext_brk || cmd_i == CMD_HALT || step_end) begin
            running_ff <= 1'h0;
            stepping_ff <= 1'h0;
         end else if (stepping_ff && instr_done_i) begin
            steps_left_ff <= steps_left_ff - 16'h0001;
         end
      end else begin
         // Each unit obeys only its own command, so two units start independently
         case (cmd_i)
            CMD_GO: begin
               running_ff <= 1'h1;
               stepping_ff <= 1'h0;
            end
            CMD_STEP: begin
               running_ff <= 1'h1;
               stepping_ff <= 1'h1;
               steps_left_ff <= (step_count_i == 16'h0000) ? 16'h0001 : step_count_i;
            end
            default: begin
               running_ff <= 1'h0;
            end
         endcase
      end
   end

   // Break flag holds until the next start
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         break_hit_ff <= 1'h0;
      end else if (brk_now || (running_ff && ext_brk)) begin
         break_hit_ff <= 1'h1;
      end else if (!running_ff && (cmd_i == CMD_GO || cmd_i == CMD_STEP)) begin
         break_hit_ff <= 1'h0;
      end
   end

   // Elapsed counter; cleared only by reset so it spans several runs
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         timer_ff <= 32'h0000_0000;
      end else if (running_ff && tick_rise) begin
         timer_ff <= timer_ff + 32'h0000_0001;
      end
   end

   // Circular write pointer over 1023 entries
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_ptr_ff <= PTR_ZERO;
      end else if (capture) begin
         // Slot 3fe is the last of 1023, so slot 3ff must never be written
         wr_ptr_ff <= (wr_ptr_ff == PTR_LAST) ? PTR_ZERO : wr_ptr_ff + 10'h001;
      end
   end

   // Valid frame count saturates at 1022, the newest slot being in flight
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         valid_ff <= PTR_ZERO;
      end else if (capture && valid_ff != VALID_MAX_V) begin
         valid_ff <= valid_ff + 10'h001;
      end
   end

   // Own event pulse: one cycle on a comparator break
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync_pulse_ff <= 1'h0;
      end else begin
         sync_pulse_ff <= brk_now;
      end
   end

   // Drive both lines when enabled: line 0 shows running, line 1 the break event
   assign sync_oe_o  = {2{sync_cfg_i.drive_en}};
   assign sync_out_o = {sync_pulse_ff, running_ff};

   // Read by age, 0 being the newest sample; the store is never cleared on halt
   always_comb begin
      if (wr_ptr_ff > rd_age_i) begin
         rd_addr = wr_ptr_ff - rd_age_i - 10'h001;
      end else begin
         rd_addr = wr_ptr_ff + PTR_LAST - rd_age_i;
      end
   end

   etb_trace_mem u_mem (
      .ref_clk_i (ref_clk_i),
      .wr_en_i   (capture),
      .wr_addr_i (wr_ptr_ff),
      .wr_data_i (smp_bits),
      .rd_addr_i (rd_addr),
      .rd_data_o (rd_data_o)
   );

   assign running_o            = running_ff;
   assign halted_o             = ~running_ff;
   assign break_hit_o          = break_hit_ff;
   assign elapsed_count_low_o  = timer_ff[HALF_W-1:0];
   assign elapsed_count_high_o = timer_ff[TIMER_W-1:HALF_W];
   assign valid_trace_depth_o  = valid_ff;

   // Checks
   a_break_stops: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      brk_now |=> !running_ff) else $error("run did not stop on break");
   a_no_wr_brk: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      brk_now |-> !capture) else $error("write on break state");
   a_cmp_match: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (pats[0].care == 42'h0) |-> hit[0]) else $error("empty pattern must match");
   a_qual_gate: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      capture |-> (qual_ok && running_ff)) else $error("unqualified write");
   a_ext_gate: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (sync_cfg_i.gate_en && !sync_s_ff[0]) |-> !capture) else $error("gated write");
   a_ext_break: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (running_ff && ext_brk) |=> !running_ff) else $error("sync break ignored");
   a_depth_cap: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      valid_ff <= VALID_MAX_V) else $error("valid depth above limit");
   a_ptr_wrap: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (capture && wr_ptr_ff == 10'h3fe) |=> wr_ptr_ff == PTR_ZERO) else $error("pointer wrap wrong");
   a_timer_idle: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      !running_ff |=> $stable(timer_ff)) else $error("timer moved while halted");
   a_step_one: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (!running_ff && cmd_i == CMD_STEP && step_count_i == 16'h0001) ##1 (instr_done_i && cmd_i != CMD_HALT)
      |=> !running_ff) else $error("single step did not halt");
   c_break: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) brk_now);
   c_wrap:  cover property (@(posedge ref_clk_i) disable iff (!rstn_i) capture && wr_ptr_ff == 10'h3fe);
   c_step:  cover property (@(posedge ref_clk_i) disable iff (!rstn_i) step_end);
   c_sync:  cover property (@(posedge ref_clk_i) disable iff (!rstn_i) running_ff && ext_brk);
endmodule

// ===== rtl/etb_pkg.sv
// Package of constants, types and carriers for the emulator trace and breakpoint unit
package etb_pkg;
   localparam int CPU_CH        = 24;
   localparam int EXT_CH        = 18;
   localparam int TRACE_CH      = 42;
   localparam int TRACE_DEPTH   = 1023;
   localparam int MAX_VALID     = 1022;
   localparam int PTR_W         = 10;
   localparam int ADDR_W        = 8;
   localparam int DATA_W        = 8;
   localparam int STAT_W        = 6;
   localparam int STEP_W        = 16;
   localparam int TIMER_W       = 32;
   localparam int HALF_W        = 16;
   localparam logic [PTR_W-1:0] PTR_LAST = 10'h3fe;
   localparam logic [PTR_W-1:0] PTR_ZERO = 10'h000;
   localparam logic [PTR_W-1:0] VALID_MAX_V = 10'h3fe;

   // One sample: processor side then probe side
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [STAT_W-1:0] status;
      logic              sid;
      logic              sod;
   } etb_cpu_t;

   typedef struct packed {
      etb_cpu_t          cpu;
      logic [EXT_CH-1:0] ext;
   } etb_sample_t;

   // Pattern: care bit and value bit per channel
   typedef struct packed {
      logic [TRACE_CH-1:0] care;
      logic [TRACE_CH-1:0] value;
   } etb_pattern_t;

   // Sync line enables and output request
   typedef struct packed {
      logic gate_en;
      logic brk_en;
      logic drive_en;
   } etb_sync_cfg_t;

   typedef enum logic [1:0] {
      CMD_NONE,
      CMD_GO,
      CMD_STEP,
      CMD_HALT
   } etb_cmd_t;
endpackage

// ===== rtl/etb_trace_mem.sv
// Trace memory with registered read data
`timescale 1ns/1ps
module etb_trace_mem
   import etb_pkg::*;
(
   input  wire logic                ref_clk_i,
   input  wire logic                wr_en_i,
   input  wire logic [PTR_W-1:0]    wr_addr_i,
   input  wire logic [TRACE_CH-1:0] wr_data_i,
   input  wire logic [PTR_W-1:0]    rd_addr_i,
   output logic      [TRACE_CH-1:0] rd_data_o
);
   logic [TRACE_CH-1:0] mem [0:TRACE_DEPTH-1];

   // Write port, no reset on the array
   always_ff @(posedge ref_clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   // Registered read port
   always_ff @(posedge ref_clk_i) begin
      rd_data_o <= mem[rd_addr_i];
   end
endmodule

// ===== sim/etb_target_model.sv
// Behavioural target processor and probe pod feeding the trace unit
`timescale 1ns/1ps
module etb_target_model
   import etb_pkg::*;
(
   input  wire logic         ref_clk_i,
   output etb_cpu_t          cpu_o,
   output logic [EXT_CH-1:0] probe_o,
   output logic              strobe_o,
   output logic              done_o,
   output logic              tick_o
);
   // Reference runs free with no phase tie to the bench clock
   initial tick_o = 1'b0;
   always #250 tick_o = ~tick_o;
   initial begin
      cpu_o    = '0;
      probe_o  = '0;
      strobe_o = 1'b0;
      done_o   = 1'b0;
   end
   // One machine state; strobe stays up so back to back states never glitch it
   task automatic emit(input logic [TRACE_CH-1:0] s, input logic last);
      {cpu_o, probe_o} = s;
      strobe_o = 1'b1;
      done_o   = last;
      @(posedge ref_clk_i);
      #1;
   endtask
   // Bus released: inverted lines so stale values cannot pose as samples
   task automatic idle();
      strobe_o = 1'b0;
      done_o   = 1'b0;
      cpu_o    = ~cpu_o;
      probe_o  = ~probe_o;
   endtask
endmodule

// ===== sim/tb_emulator_trace_and_breakpoint_unit.sv
// Self-checking bench for the trace and breakpoint unit
`timescale 1ns/1ps
module tb_emulator_trace_and_breakpoint_unit;
   import etb_pkg::*;
   localparam etb_pattern_t NEVER = {{TRACE_CH{1'b1}}, {TRACE_CH{1'b0}}};
   logic                ref_clk_i = 1'b0;
   logic                rstn_i, state_strobe_i, instr_done_i, tick_2mhz_i, qual_en_i;
   etb_cpu_t            cpu_i;
   logic [EXT_CH-1:0]   probe_i;
   etb_cmd_t            cmd_i;
   logic [STEP_W-1:0]   step_count_i;
   etb_pattern_t        brk_pat0_i, brk_pat1_i, qual_pat0_i, qual_pat1_i;
   etb_sync_cfg_t       sync_cfg_i;
   logic [1:0]          sync_in_i, sync_out_o, sync_oe_o;
   logic [PTR_W-1:0]    rd_age_i, valid_trace_depth_o;
   logic [TRACE_CH-1:0] rd_data_o, x;
   logic                running_o, halted_o, break_hit_o;
   logic [HALF_W-1:0]   elapsed_count_low_o, elapsed_count_high_o;
   int                  err_count = 0, n_checks = 0, seed = 32'h518bbfcc, e0, n;
   logic [TRACE_CH-1:0] hist[$];
   always #12.5 ref_clk_i = ~ref_clk_i;
   etb_unit dut (.*);
   etb_target_model tm (.ref_clk_i(ref_clk_i), .cpu_o(cpu_i), .probe_o(probe_i),
      .strobe_o(state_strobe_i), .done_o(instr_done_i), .tick_o(tick_2mhz_i));
   // Comparisons, one per kind of result
   task automatic chk_vec(input logic [TRACE_CH-1:0] g, input logic [TRACE_CH-1:0] e);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %0t value got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, input logic e);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %0t flag got %b exp %b", $time, g, e);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic cmd(input etb_cmd_t c);
      cmd_i = c;
      tick(1);
      cmd_i = CMD_NONE;
   endtask
   function automatic logic hit(input etb_pattern_t p, input logic [TRACE_CH-1:0] s);
      return ((s ^ p.value) & p.care) == '0;
   endfunction
   function automatic logic [TRACE_CH-1:0] rnd();
      return TRACE_CH'({$random(seed), $random(seed)});
   endfunction
   // Reference decides whether the state lands in the store, then drives it
   task automatic state(input logic [TRACE_CH-1:0] s, input logic last);
      logic brk;
      logic qual;
      brk  = hit(brk_pat0_i, s) || hit(brk_pat1_i, s);
      qual = !qual_en_i || hit(qual_pat0_i, s) || hit(qual_pat1_i, s);
      if (running_o === 1'b1 && !brk && qual && (!sync_cfg_i.gate_en || sync_in_i[0])) hist.push_back(s);
      tm.emit(s, last);
   endtask
   task automatic run(input int k);
      repeat (k) state(rnd(), 1'b0);
      tm.idle();
   endtask
   // Depth and history by age, including the oldest frame once wrapped
   task automatic chk_hist(input string name);
      int ages[4] = '{0, 1, 2, MAX_VALID - 1};
      tick(2);
      chk_vec(TRACE_CH'(valid_trace_depth_o), TRACE_CH'(hist.size() > MAX_VALID ? MAX_VALID : hist.size()));
      foreach (ages[i]) if (ages[i] < hist.size()) begin
         rd_age_i = PTR_W'(ages[i]);
         tick(2);
         chk_vec(rd_data_o, hist[hist.size() - 1 - ages[i]]);
      end
      $display("%s done", name);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Watchdog sized well above the roughly 3200 cycles of the sequence
   initial begin
      #(25 * 20000);
      err_count++;
      $display("ERROR %0t watchdog expired", $time);
      final_report();
   end
   // Main sequence
   initial begin
      {rstn_i, qual_en_i, rd_age_i, step_count_i, sync_cfg_i} = '0;
      cmd_i = CMD_NONE;
      sync_in_i = 2'b01;
      {brk_pat0_i, brk_pat1_i, qual_pat0_i, qual_pat1_i} = {NEVER, NEVER, NEVER, NEVER};
      tick(8);
      rstn_i = 1'b1;
      tick(1);
      chk_bit(halted_o, 1'b1);
      chk_vec(TRACE_CH'({elapsed_count_high_o, elapsed_count_low_o}), '0);
      chk_hist("reset");
      // Processor-channel break on one comparator, probe-channel break on the other
      sync_cfg_i = 3'b001;
      for (int p = 0; p < 2; p++) begin
         x = p ? {24'h0, 18'h2aaaa} : {24'ha5c35a, 18'h0};
         if (p) brk_pat1_i = {{24'h0, 18'h3ffff}, x};
         else brk_pat0_i = {{24'hffffff, 18'h0}, x};
         cmd(CMD_GO);
         chk_bit(running_o, 1'b1);
         chk_bit(break_hit_o, 1'b0);
         run(5 + 3 * p);
         state(x, 1'b0);
         tm.idle();
         chk_vec(TRACE_CH'({sync_oe_o, sync_out_o, running_o, break_hit_o}), TRACE_CH'(6'b111001));
         {brk_pat0_i, brk_pat1_i} = {NEVER, NEVER};
         chk_hist("comparator break");
      end
      // Qualified capture of odd samples only, stopped by command
      qual_en_i = 1'b1;
      qual_pat0_i = {42'h1, 42'h1};
      cmd(CMD_GO);
      run(20);
      cmd(CMD_HALT);
      chk_bit(break_hit_o, 1'b0);
      chk_hist("qualifier");
      qual_en_i = 1'b0;
      // Gate line closed then opened
      sync_cfg_i = 3'b100;
      for (int g = 0; g < 2; g++) begin
         sync_in_i[0] = g[0];
         tick(4);
         cmd(CMD_GO);
         run(6);
         cmd(CMD_HALT);
         chk_hist("gate");
      end
      // External break line
      sync_cfg_i = 3'b010;
      cmd(CMD_GO);
      run(3);
      sync_in_i[1] = 1'b1;
      for (int w = 0; w < 8 && halted_o !== 1'b1; w++) tick(1);
      chk_bit(break_hit_o, 1'b1);
      sync_in_i[1] = 1'b0;
      sync_cfg_i = 3'b000;
      chk_hist("sync break");
      // Stepping with a count of zero (one step), of one and of three
      for (int k = 0; k < 3; k++) begin
         step_count_i = (k == 2) ? STEP_W'(3) : STEP_W'(k);
         n = (k == 2) ? 3 : 1;
         cmd(CMD_STEP);
         repeat (n) begin
            chk_bit(running_o, 1'b1);
            state(rnd(), 1'b1);
         end
         tm.idle();
         for (int w = 0; w < 4 && halted_o !== 1'b1; w++) tick(1);
         chk_bit(halted_o, 1'b1);
         chk_hist("step");
      end
      // Elapsed time: 2000 cycles is 100 reference periods
      e0 = int'({elapsed_count_high_o, elapsed_count_low_o});
      cmd(CMD_GO);
      tick(2000);
      cmd(CMD_HALT);
      tick(4);
      e0 = int'({elapsed_count_high_o, elapsed_count_low_o}) - e0;
      chk_bit(e0 >= 98 && e0 <= 102, 1'b1);
      $display("elapsed done");
      // Wrap the store past its depth
      cmd(CMD_GO);
      run(1030);
      cmd(CMD_HALT);
      chk_hist("wrap");
      final_report();
   end
endmodule
